// >>> scc_defines.vh
`ifndef SCC_DEFINES_VH
`define SCC_DEFINES_VH

// ********************************************************************
// Register indices (byte address is four times the index)
// ********************************************************************
`define SCC_IDX_TBC      8'h36
`define SCC_IDX_SYSC1    8'h38
`define SCC_IDX_SYSC2    8'h39
`define SCC_IDX_DIVC     8'h3A
`define SCC_IDX_STAT     8'h3B

// ********************************************************************
// Reset values
// ********************************************************************
`define SCC_RST_TBC      8'h00
`define SCC_RST_SYSC1    8'h00
`define SCC_RST_SYSC2    8'h80
`define SCC_RST_DIVC     8'h00

// ********************************************************************
// Field positions
// ********************************************************************
`define SCC_S1_HALT      7
`define SCC_S1_TRIG      6
`define SCC_S1_RET       5
`define SCC_S1_HOLD      4
`define SCC_S1_WUT_HI    3
`define SCC_S1_WUT_LO    2
`define SCC_S2_OSC       7
`define SCC_S2_SYSCK     5
`define SCC_S2_IDLE      4
`define SCC_DC_STAGE     5
`define SCC_TB_DVO_EN    7
`define SCC_TB_DVO_HI    6
`define SCC_TB_DVO_LO    5
`define SCC_TB_ZERO      4
`define SCC_TB_EN        3
`define SCC_TB_RATE_HI   2
`define SCC_TB_RATE_LO   0

// ********************************************************************
// Warm-up codes and divider taps
// ********************************************************************
`define SCC_WU_LONG      2'h0
`define SCC_WU_MID       2'h1
`define SCC_WU_SHORT     2'h2
`define SCC_DVO_TAP      5'h0A
`define SCC_TB_TAP       5'h0D

`endif

// >>> scc_sync.v
`timescale 1ns/1ns
module scc_sync #(
   parameter         W    = 2,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   // Clock and reset
   input  wire         mclk_in,
   input  wire         sys_rst_in,
   // Raw pins and filtered levels
   input  wire [W-1:0] pin_in,
   output reg  [W-1:0] level_out
);

   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;

   // Three stages; level follows once stages two and three agree
   always @(posedge mclk_in) begin
      if (sys_rst_in) begin
         s1_q      <= INIT;
         s2_q      <= INIT;
         s3_q      <= INIT;
         level_out <= INIT;
      end else begin
         s1_q      <= pin_in;
         s2_q      <= s1_q;
         s3_q      <= s2_q;
         level_out <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & level_out);
      end
   end

endmodule // scc_sync

// >>> scc_divider.v
`timescale 1ns/1ns
module scc_divider #(
   parameter PRE_W = 3,
   parameter DIV_W = 21
) (
   // Clock and reset
   input  wire                   mclk_in,
   input  wire                   sys_rst_in,
   // Chain control
   input  wire                   clear_in,
   input  wire                   run_in,
   output wire [PRE_W+DIV_W-1:0] chain_out,
   // Machine cycle
   input  wire                   cpu_run_in,
   input  wire [3:0]             instr_cycles_in,
   output reg  [1:0]             mc_state_out,
   output reg  [3:0]             mc_cycle_out,
   output reg                    instr_done_out
);

   reg  [PRE_W-1:0] pre_q;
   reg  [DIV_W-1:0] div_q;
   wire [3:0]       len;

   assign chain_out = {div_q, pre_q};
   assign len       = (instr_cycles_in == 4'h0) ? 4'h1 : instr_cycles_in;

   // ****************************************************************
   // Prescaler and divider chain
   // ****************************************************************
   always @(posedge mclk_in) begin
      if (sys_rst_in || clear_in) begin
         pre_q <= {PRE_W{1'b0}};
         div_q <= {DIV_W{1'b0}};
      end else if (run_in) begin
         pre_q <= pre_q + 1'b1;
         if (&pre_q) begin
            div_q <= div_q + 1'b1;
         end
      end
   end

   // ****************************************************************
   // Machine-cycle counter
   // ****************************************************************
   always @(posedge mclk_in) begin
      if (sys_rst_in) begin
         mc_state_out   <= 2'h0;
         mc_cycle_out   <= 4'h1;
         instr_done_out <= 1'b0;
      end else begin
         instr_done_out <= 1'b0;
         if (cpu_run_in) begin
            mc_state_out <= mc_state_out + 2'h1;
            if (mc_state_out == 2'h3) begin
               if (mc_cycle_out >= len) begin
                  mc_cycle_out   <= 4'h1;
                  instr_done_out <= 1'b1;
               end else begin
                  mc_cycle_out <= mc_cycle_out + 4'h1;
               end
            end
         end
      end
   end

endmodule // scc_divider

// >>> scc_top.v
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "scc_defines.vh"
module scc_top #(
   parameter [23:0] WU_LONG_CYC  = 24'h03_0000,
   parameter [23:0] WU_MID_CYC   = 24'h01_0000,
   parameter [23:0] WU_SHORT_CYC = 24'h00_4000
) (
   // Clock and reset
   input  wire        mclk_in,
   input  wire        sys_rst_in,
   // Device pins
   input  wire        reset_pin_n_in,
   input  wire        wake_pin_in,
   output reg         divider_pulse_output_n_out,
   // Avalon-MM slave
   input  wire [9:0]  avs_address_in,
   input  wire        avs_read_in,
   input  wire        avs_write_in,
   input  wire [31:0] avs_writedata_in,
   input  wire [3:0]  avs_byteenable_in,
   output reg  [31:0] avs_readdata_out,
   output wire        avs_waitrequest_out,
   // Core side
   input  wire        irq_in,
   input  wire        interrupt_master_flag_in,
   input  wire [3:0]  instr_cycles_in,
   // Clock gating and mode
   output wire        osc_run_out,
   output wire        cpu_clk_en_out,
   output wire        wdt_clk_en_out,
   output wire        periph_clk_en_out,
   output wire        core_reset_out,
   output wire        port_hiz_out,
   // Machine cycle
   output wire [1:0]  mc_state_out,
   output wire [3:0]  mc_cycle_out,
   output wire        instr_done_out,
   // Events
   output reg         resume_next_out,
   output reg         irq_service_out,
   output reg         timebase_tick_out
);

   localparam [2:0] ST_NORMAL = 3'h0;
   localparam [2:0] ST_IDLE   = 3'h1;
   localparam [2:0] ST_STOP   = 3'h2;
   localparam [2:0] ST_WARM   = 3'h3;
   localparam [7:0] RST_S1    = `SCC_RST_SYSC1;
   localparam [7:0] RST_S2    = `SCC_RST_SYSC2;
   localparam [7:0] RST_DC    = `SCC_RST_DIVC;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   wire [1:0]  pins_lvl;
   wire        wake_lvl;
   wire        pin_rst;
   wire        rst_all;
   wire [23:0] chain;
   wire        req;
   wire        wr_fire;
   wire        wr_b0;
   wire [7:0]  wdata;
   wire        wake_rise;
   wire        stop_wake;
   wire [23:0] wu_base;
   wire [23:0] wu_target;
   wire        wu_done;
   wire [4:0]  dvo_idx;
   wire [4:0]  tb_idx;
   reg  [7:0]  rd_mux;
   reg  [2:0]  state_q;
   reg  [2:0]  state_d;
   reg         chain_clr_d;
   reg         ack_q;
   reg         soft_rst_q;
   reg         wake_prev_q;
   reg         stop_edge_q;
   reg         tb_prev_q;
   reg  [7:0]  tbc_q;
   reg         halt_q;
   reg         trig_q;
   reg         ret_q;
   reg         hold_q;
   reg  [1:0]  wut_q;
   reg         osc_q;
   reg         sysck_q;
   reg         idle_q;
   reg         stage_q;

   // ****************************************************************
   // Pin synchronisers and reset sources
   // ****************************************************************
   scc_sync #(
      .W    (2),
      .INIT (2'h2)
   ) u_sync (
      .mclk_in    (mclk_in),
      .sys_rst_in (sys_rst_in),
      .pin_in     ({reset_pin_n_in, wake_pin_in}),
      .level_out  (pins_lvl)
   );

   assign wake_lvl       = pins_lvl[0];
   assign pin_rst        = ~pins_lvl[1];
   assign rst_all        = sys_rst_in | pin_rst | soft_rst_q;
   assign core_reset_out = rst_all;

   // ****************************************************************
   // Timing generator
   // ****************************************************************
   scc_divider #(
      .PRE_W (3),
      .DIV_W (21)
   ) u_div (
      .mclk_in         (mclk_in),
      .sys_rst_in      (rst_all),
      .clear_in        (chain_clr_d),
      .run_in          (state_q != ST_STOP),
      .chain_out       (chain),
      .cpu_run_in      (cpu_clk_en_out),
      .instr_cycles_in (instr_cycles_in),
      .mc_state_out    (mc_state_out),
      .mc_cycle_out    (mc_cycle_out),
      .instr_done_out  (instr_done_out)
   );

   // ****************************************************************
   // Clock gating
   // ****************************************************************
   assign osc_run_out       = (state_q != ST_STOP) & ~rst_all;
   assign cpu_clk_en_out    = (state_q == ST_NORMAL) & ~rst_all;
   assign wdt_clk_en_out    = (state_q == ST_NORMAL) & ~rst_all;
   assign periph_clk_en_out = ((state_q == ST_NORMAL) |
                               (state_q == ST_IDLE)) & ~rst_all;
   assign port_hiz_out      = (state_q == ST_STOP) & ~hold_q;

   // ****************************************************************
   // Avalon-MM handshake
   // ****************************************************************
   assign req                 = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = req & ~ack_q;
   assign wr_fire             = avs_write_in & ack_q;
   assign wr_b0               = wr_fire & avs_byteenable_in[0];
   assign wdata               = avs_writedata_in[7:0];

   always @(posedge mclk_in) begin
      if (sys_rst_in) begin
         ack_q            <= 1'b0;
         avs_readdata_out <= 32'h0000_0000;
      end else begin
         ack_q <= req & ~ack_q;
         if (avs_read_in && !ack_q) begin
            avs_readdata_out <= {24'h00_0000, rd_mux};
         end
      end
   end

   // ****************************************************************
   // Read multiplexer
   // ****************************************************************
   always @* begin
      rd_mux = 8'h00;
      case (avs_address_in)
         {`SCC_IDX_TBC, 2'h0}:   rd_mux = tbc_q;
         {`SCC_IDX_SYSC1, 2'h0}: rd_mux = {halt_q, trig_q, ret_q, hold_q,
                                           wut_q, 2'h0};
         {`SCC_IDX_SYSC2, 2'h0}: rd_mux = {osc_q, 1'b0, sysck_q, idle_q,
                                           4'h0};
         {`SCC_IDX_DIVC, 2'h0}:  rd_mux = {2'h0, stage_q, 5'h00};
         {`SCC_IDX_STAT, 2'h0}:  rd_mux = {5'h00, state_q};
         default:                rd_mux = 8'h00;
      endcase
   end

   // ****************************************************************
   // Wake detection and warm-up target
   // ****************************************************************
   assign wake_rise = wake_lvl & ~wake_prev_q;
   assign stop_wake = wake_rise |
                      (trig_q & ~stop_edge_q & wake_lvl);

   assign wu_base   = (wut_q == `SCC_WU_MID)   ? WU_MID_CYC :
                      (wut_q == `SCC_WU_SHORT) ? WU_SHORT_CYC :
                                                 WU_LONG_CYC;
   assign wu_target = stage_q ? {wu_base[22:0], 1'b0} : wu_base;
   assign wu_done   = (chain == (wu_target - 24'h00_0001));

   // ****************************************************************
   // Mode sequencer
   // ****************************************************************
   always @* begin
      state_d     = state_q;
      chain_clr_d = 1'b0;
      case (state_q)
         ST_NORMAL: begin
            if (halt_q) begin
               chain_clr_d = 1'b1;
               if (trig_q && wake_lvl) begin
                  state_d = ST_WARM;
               end else begin
                  state_d = ST_STOP;
               end
            end else if (idle_q) begin
               state_d = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (irq_in) begin
               state_d = ST_NORMAL;
            end
         end
         ST_STOP: begin
            if (stop_wake) begin
               state_d     = ST_WARM;
               chain_clr_d = 1'b1;
            end
         end
         ST_WARM: begin
            if (wu_done) begin
               state_d     = ST_NORMAL;
               chain_clr_d = 1'b1;
            end
         end
         default: begin
            state_d     = ST_NORMAL;
            chain_clr_d = 1'b1;
         end
      endcase
   end

   // ****************************************************************
   // Control registers and mode state
   // ****************************************************************
   always @(posedge mclk_in) begin
      if (sys_rst_in) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= wr_b0 &&
                       (avs_address_in == {`SCC_IDX_SYSC2, 2'h0}) &&
                       !wdata[`SCC_S2_OSC];
      end
   end

   always @(posedge mclk_in) begin
      if (rst_all) begin
         state_q         <= ST_NORMAL;
         tbc_q           <= `SCC_RST_TBC;
         halt_q          <= RST_S1[`SCC_S1_HALT];
         trig_q          <= RST_S1[`SCC_S1_TRIG];
         ret_q           <= RST_S1[`SCC_S1_RET];
         hold_q          <= RST_S1[`SCC_S1_HOLD];
         wut_q           <= RST_S1[`SCC_S1_WUT_HI:`SCC_S1_WUT_LO];
         osc_q           <= RST_S2[`SCC_S2_OSC];
         sysck_q         <= RST_S2[`SCC_S2_SYSCK];
         idle_q          <= RST_S2[`SCC_S2_IDLE];
         stage_q         <= RST_DC[`SCC_DC_STAGE];
         stop_edge_q     <= 1'b0;
         resume_next_out <= 1'b0;
         irq_service_out <= 1'b0;
      end else begin
         state_q         <= state_d;
         resume_next_out <= 1'b0;
         irq_service_out <= 1'b0;
         if (wr_b0) begin
            case (avs_address_in)
               {`SCC_IDX_TBC, 2'h0}: begin
                  tbc_q <= wdata & ~(8'h01 << `SCC_TB_ZERO);
               end
               {`SCC_IDX_SYSC1, 2'h0}: begin
                  halt_q <= wdata[`SCC_S1_HALT];
                  trig_q <= wdata[`SCC_S1_TRIG];
                  ret_q  <= wdata[`SCC_S1_RET];
                  hold_q <= wdata[`SCC_S1_HOLD];
                  wut_q  <= wdata[`SCC_S1_WUT_HI:`SCC_S1_WUT_LO];
               end
               {`SCC_IDX_SYSC2, 2'h0}: begin
                  osc_q   <= wdata[`SCC_S2_OSC];
                  sysck_q <= wdata[`SCC_S2_SYSCK];
                  idle_q  <= wdata[`SCC_S2_IDLE];
               end
               {`SCC_IDX_DIVC, 2'h0}: begin
                  stage_q <= wdata[`SCC_DC_STAGE];
               end
               default: begin
                  stage_q <= stage_q;
               end
            endcase
         end
         if (state_q == ST_NORMAL && halt_q) begin
            stop_edge_q <= ~trig_q;
         end
         if (state_q == ST_IDLE && irq_in) begin
            idle_q          <= 1'b0;
            irq_service_out <= interrupt_master_flag_in;
            resume_next_out <= ~interrupt_master_flag_in;
         end
         if (state_q == ST_WARM && wu_done) begin
            halt_q          <= 1'b0;
            resume_next_out <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Divider pulse output and time base tick
   // ****************************************************************
   assign dvo_idx = `SCC_DVO_TAP +
                    {3'h0, tbc_q[`SCC_TB_DVO_HI:`SCC_TB_DVO_LO]};
   assign tb_idx  = `SCC_TB_TAP +
                    {2'h0, tbc_q[`SCC_TB_RATE_HI:`SCC_TB_RATE_LO]};

   always @(posedge mclk_in) begin
      if (rst_all) begin
         divider_pulse_output_n_out <= 1'b1;
         timebase_tick_out          <= 1'b0;
         wake_prev_q                <= 1'b0;
         tb_prev_q                  <= 1'b0;
      end else begin
         wake_prev_q <= wake_lvl;
         tb_prev_q   <= chain[tb_idx];
         divider_pulse_output_n_out <= ~(tbc_q[`SCC_TB_DVO_EN] &
                                         chain[dvo_idx]);
         timebase_tick_out <= tbc_q[`SCC_TB_EN] & chain[tb_idx] &
                              ~tb_prev_q & (state_q == ST_NORMAL);
      end
   end

endmodule // scc_top

// >>> scc_assertions.sv
`timescale 1ns/1ns
module scc_chk #(
   parameter [23:0] WU_LONG_CYC  = 24'h03_0000,
   parameter [23:0] WU_MID_CYC   = 24'h01_0000,
   parameter [23:0] WU_SHORT_CYC = 24'h00_4000
) (
   // Clock and resets
   input wire       mclk_in,
   input wire       sys_rst_in,
   input wire       reset_pin_n_in,
   // Pins and core side
   input wire       wake_pin_in,
   input wire       irq_in,
   input wire       interrupt_master_flag_in,
   // Watched outputs
   input wire       osc_run_out,
   input wire       cpu_clk_en_out,
   input wire       wdt_clk_en_out,
   input wire       periph_clk_en_out,
   input wire       core_reset_out,
   input wire       port_hiz_out,
   input wire [1:0] mc_state_out,
   input wire       instr_done_out,
   input wire       resume_next_out,
   input wire       irq_service_out
);
   // ******
   // Warm-up counter
   // ******
   wire        warm = osc_run_out && !periph_clk_en_out && !core_reset_out;
   reg  [23:0] wcnt_q;
   wire [23:0] wcnt_d = warm ? wcnt_q + 24'h00_0001 : 24'h00_0000;
   always @(posedge mclk_in) begin
      wcnt_q <= sys_rst_in ? 24'h00_0000 : wcnt_d;
   end
   // ******
   // Properties
   // ******
   default clocking @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   a_reset_run: assert property ($fell(sys_rst_in) && reset_pin_n_in
      |-> cpu_clk_en_out && osc_run_out && !core_reset_out)
      else $error("core not running after reset");
   a_idle_gates: assert property (periph_clk_en_out && !cpu_clk_en_out
      |-> !wdt_clk_en_out && osc_run_out) else $error("idle gating wrong");
   a_idle_wakes: assert property (periph_clk_en_out && !cpu_clk_en_out
      && irq_in |=> cpu_clk_en_out
      && irq_service_out == $past(interrupt_master_flag_in)
      && resume_next_out != $past(interrupt_master_flag_in))
      else $error("idle exit wrong");
   a_halt_stops: assert property (!osc_run_out
      |-> !cpu_clk_en_out && !periph_clk_en_out) else $error("clock in halt");
   a_hiz_halt: assert property (port_hiz_out |-> !osc_run_out)
      else $error("port floats outside halt");
   a_state_steps: assert property (cpu_clk_en_out |=> core_reset_out
      || mc_state_out == $past(mc_state_out) + 2'h1)
      else $error("machine state skipped");
   a_done_s3: assert property (instr_done_out
      |-> $past(mc_state_out) == 2'h3) else $error("done not after S3");
   a_wake_rise: assert property ($rose(wake_pin_in) && !osc_run_out
      && !core_reset_out |-> ##[2:10] osc_run_out) else $error("no wake");
   a_warm_span: assert property ($fell(warm) && cpu_clk_en_out
      |-> wcnt_q >= WU_SHORT_CYC && wcnt_q <= 2 * WU_LONG_CYC)
      else $error("warm-up length out of range");
   a_warm_resume: assert property ($fell(warm) && cpu_clk_en_out
      |-> resume_next_out) else $error("no resume after warm-up");
   a_pin_reset: assert property ($fell(reset_pin_n_in)
      |-> ##[3:6] core_reset_out) else $error("pin reset ignored");
   c_mid_warm: cover property (wcnt_q == WU_MID_CYC);
endmodule // scc_chk

bind scc_top scc_chk #(
   .WU_LONG_CYC(WU_LONG_CYC), .WU_MID_CYC(WU_MID_CYC),
   .WU_SHORT_CYC(WU_SHORT_CYC)
) scc_chk_i (
   .mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
   .reset_pin_n_in(reset_pin_n_in), .wake_pin_in(wake_pin_in),
   .irq_in(irq_in), .interrupt_master_flag_in(interrupt_master_flag_in),
   .osc_run_out(osc_run_out), .cpu_clk_en_out(cpu_clk_en_out),
   .wdt_clk_en_out(wdt_clk_en_out), .periph_clk_en_out(periph_clk_en_out),
   .core_reset_out(core_reset_out), .port_hiz_out(port_hiz_out),
   .mc_state_out(mc_state_out), .instr_done_out(instr_done_out),
   .resume_next_out(resume_next_out), .irq_service_out(irq_service_out)
);

// >>> scc_wake_src.sv
`timescale 1ns/1ns
module scc_wake_src (
   // Clock
   input  wire mclk_in,
   // Pins toward the device
   output reg  wake_out,
   output reg  reset_n_out
);
   initial begin
      wake_out = 1'b0;
      reset_n_out = 1'b1;
   end
   // ******
   // Pin drivers
   // ******
   task set_wake(input reg v);
      @(posedge mclk_in);
      wake_out <= v;
   endtask
   task pulse_reset(input integer len);
      @(posedge mclk_in);
      reset_n_out <= 1'b0;
      repeat (len) @(posedge mclk_in);
      reset_n_out <= 1'b1;
   endtask
endmodule // scc_wake_src

// >>> scc_top_tb_top.sv
`timescale 1ns/1ns
module scc_top_tb_top;
   // ******
   // Signals and tables
   // ******
   reg         mclk_in = 1'b0;
   reg         sys_rst_in = 1'b1;
   reg  [9:0]  avs_address_in = 10'h000;
   reg         avs_read_in = 1'b0;
   reg         avs_write_in = 1'b0;
   reg  [31:0] avs_writedata_in = 32'h0000_0000;
   reg  [3:0]  avs_byteenable_in = 4'h0;
   reg         irq_in = 1'b0;
   reg         master_flag = 1'b0;
   reg  [3:0]  instr_cycles_in = 4'hF;
   wire [31:0] avs_readdata_out;
   wire        avs_waitrequest_out, pin_wake, pin_rst_n, osc_run_out;
   wire        cpu_clk_en_out, periph_clk_en_out, port_hiz_out;
   wire        wdt_clk_en_out, core_reset_out;
   wire        irq_service_out, resume_next_out;
   integer     bad_count = 0;
   integer     checked = 0;
   integer     cyc = 0;
   integer     i, n;
   reg         seen;
   reg  [7:0]  rd;
   localparam [95:0]  RT = {16'hD800, 16'hE000, 16'hE480, 16'hE800,
                            16'hEC00, 16'hF000};
   localparam [223:0] WT = {32'hD8FF_01EF, 32'hE8FF_0020, 32'hE8FF_0120,
      32'hE07F_017C, 32'hF0FF_0100, 32'hE000_0100, 32'hE800_0100};
   localparam [127:0] WU = {32'h0000_0030, 32'h0000_0008, 32'h0000_0010,
                            32'h0000_0030};
   scc_top #(.WU_LONG_CYC(24'h00_0030), .WU_MID_CYC(24'h00_0010),
      .WU_SHORT_CYC(24'h00_0008)) scc_top_i (
      .mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
      .reset_pin_n_in(pin_rst_n), .wake_pin_in(pin_wake),
      .divider_pulse_output_n_out(), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .irq_in(irq_in),
      .interrupt_master_flag_in(master_flag),
      .instr_cycles_in(instr_cycles_in), .osc_run_out(osc_run_out),
      .cpu_clk_en_out(cpu_clk_en_out), .wdt_clk_en_out(wdt_clk_en_out),
      .periph_clk_en_out(periph_clk_en_out),
      .core_reset_out(core_reset_out),
      .port_hiz_out(port_hiz_out), .mc_state_out(), .mc_cycle_out(),
      .instr_done_out(), .resume_next_out(resume_next_out),
      .irq_service_out(irq_service_out), .timebase_tick_out());
   scc_wake_src scc_wake_src_i (.mclk_in(mclk_in), .wake_out(pin_wake),
      .reset_n_out(pin_rst_n));
   // ******
   // Clock, timeout and tasks
   // ******
   always #10 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count = bad_count + 1;
         close_out;
      end
   end
   task close_out;
      $display("Comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input string what, input [31:0] exp, input [31:0] got);
      checked = checked + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("ERROR %0s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task bus(input w, input [9:0] a, input [7:0] d, input be,
            output [7:0] q);
      @(posedge mclk_in);
      avs_address_in <= a;
      avs_write_in <= w;
      avs_read_in <= !w;
      avs_writedata_in <= {24'h00_0000, d};
      avs_byteenable_in <= {3'h0, be};
      @(posedge mclk_in);
      while (avs_waitrequest_out !== 1'b0)
         @(posedge mclk_in);
      q = avs_readdata_out[7:0];
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask
   task halt_wake(input [7:0] s1, input exp_seen, input [31:0] tgt);
      n = 0;
      seen = 1'b0;
      bus(1'b1, 10'h0E0, s1, 1'b1, rd);
      while (!(n > 0 && cpu_clk_en_out)) begin
         @(negedge mclk_in);
         if (!osc_run_out && !seen) begin
            seen = 1'b1;
            chk("port_hiz", {31'h0, !s1[4]}, port_hiz_out);
            scc_wake_src_i.set_wake(1'b1);
         end
         if (osc_run_out && !periph_clk_en_out)
            n = n + 1;
      end
      chk("halt_entered", exp_seen, seen);
      chk("warm_cycles", tgt, n);
      bus(1'b0, 10'h0E0, 8'h00, 1'b1, rd);
      chk("sysc1_after", s1 & 8'h7C, rd);
      scc_wake_src_i.set_wake(1'b0);
      repeat (6) @(posedge mclk_in);
   endtask
   // ******
   // Test sequence
   // ******
   initial begin
      repeat (6) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      for (i = 0; i < 6; i = i + 1) begin
         bus(1'b0, {2'h0, RT[i*16+8 +: 8]}, 8'h00, 1'b1, rd);
         chk("reset_value", RT[i*16 +: 8], rd);
      end
      for (i = 0; i < 7; i = i + 1) begin
         bus(1'b1, {2'h0, WT[i*32+24 +: 8]}, WT[i*32+16 +: 8],
             WT[i*32+8], rd);
         bus(1'b0, {2'h0, WT[i*32+24 +: 8]}, 8'h00, 1'b1, rd);
         chk("readback", WT[i*32 +: 8], rd);
      end
      bus(1'b1, 10'h0E8, 8'h00, 1'b1, rd);
      for (i = 0; i < 4; i = i + 1)
         halt_wake({3'h4, i[0], i[1:0], 2'h0}, 1'b1, WU[i*32 +: 32]);
      bus(1'b1, 10'h0E8, 8'h20, 1'b1, rd);
      halt_wake(8'h98, 1'b1, 32'h0000_0010);
      bus(1'b1, 10'h0E8, 8'h00, 1'b1, rd);
      halt_wake(8'hB8, 1'b1, 32'h0000_0008);
      scc_wake_src_i.set_wake(1'b1);
      repeat (6) @(posedge mclk_in);
      halt_wake(8'hD8, 1'b0, 32'h0000_0008);
      halt_wake(8'hD8, 1'b1, 32'h0000_0008);
      bus(1'b1, 10'h0E0, 8'hB0, 1'b1, rd);
      repeat (4) @(posedge mclk_in);
      scc_wake_src_i.pulse_reset(8);
      repeat (10) @(posedge mclk_in);
      bus(1'b0, 10'h0EC, 8'h00, 1'b1, rd);
      chk("mode_after_pin", 32'h0000_0000, rd);
      for (i = 0; i < 2; i = i + 1) begin
         bus(1'b1, 10'h0E4, 8'h90, 1'b1, rd);
         repeat (2) @(negedge mclk_in);
         chk("idle_cpu", 32'h0000_0000, cpu_clk_en_out);
         chk("idle_wdt", 32'h0000_0000, wdt_clk_en_out);
         chk("idle_periph", 32'h0000_0001, periph_clk_en_out);
         @(posedge mclk_in);
         master_flag <= i[0];
         irq_in <= 1'b1;
         instr_cycles_in <= 4'h1;
         @(posedge mclk_in);
         irq_in <= 1'b0;
         @(negedge mclk_in);
         chk("idle_left", 32'h0000_0001, cpu_clk_en_out);
         chk("serviced", i[0], irq_service_out);
         chk("resumed", !i[0], resume_next_out);
         bus(1'b0, 10'h0E4, 8'h00, 1'b1, rd);
         chk("idle_cleared", 32'h0000_0080, rd);
      end
      bus(1'b1, 10'h0E4, 8'h00, 1'b1, rd);
      @(negedge mclk_in);
      chk("soft_reset", 32'h0000_0001, core_reset_out);
      bus(1'b0, 10'h0E4, 8'h00, 1'b1, rd);
      chk("osc_restored", 32'h0000_0080, rd);
      close_out;
   end
endmodule // scc_top_tb_top
